// file: src/bio_top.sv
`timescale 1ns/10ps
// Functional notes
// R1: Direction bit zero: sample pin, no drive
// R2: Direction bit one: drive pin from data
// R3: Input pin reads one high, zero low
// R4: Switch reads high released, low pressed
// R5: Four low LED pins lit on zero
// R6: Each segment bit lit on zero
// R7: Reset clears every direction bit
module bio_top
  import bio_pkg::*;
(
  input wire logic mclk_i,
  input wire logic reset_i,
  input wire logic [bio_pkg::ADDR_W-1:0] addr_i,
  input wire logic [bio_pkg::PORT_W-1:0] wdata_i,
  input wire logic wr_i,
  input wire logic rd_i,
  output logic [bio_pkg::PORT_W-1:0] rdata_o,
  input wire logic [bio_pkg::PORT_W-1:0] switch_pin_i,
  output logic [bio_pkg::PORT_W-1:0] switch_pin_o,
  output logic [bio_pkg::PORT_W-1:0] switch_pin_oe_o,
  input wire logic [bio_pkg::PORT_W-1:0] led_pin_i,
  output logic [bio_pkg::PORT_W-1:0] led_pin_o,
  output logic [bio_pkg::PORT_W-1:0] led_pin_oe_o,
  input wire logic [bio_pkg::PORT_W-1:0] seg_pin_i,
  output logic [bio_pkg::PORT_W-1:0] seg_pin_o,
  output logic [bio_pkg::PORT_W-1:0] seg_pin_oe_o,
  output logic push_switch_a_pressed_o,
  output logic [bio_pkg::LED_N-1:0] led_lit_o,
  output logic [bio_pkg::SEG_N-1:0] seg_lit_o
);
  import bio_pkg::*;
  logic [PORT_CNT-1:0] dir_we;
  logic [PORT_CNT-1:0] data_we;
  logic [PORT_W-1:0] pin_in [PORT_CNT];
  logic [PORT_W-1:0] pin_out [PORT_CNT];
  logic [PORT_W-1:0] pin_oe [PORT_CNT];
  logic [PORT_W-1:0] port_rd [PORT_CNT];
  logic [PORT_W-1:0] rdata_r;
  logic [PORT_W-1:0] rdata_nxt;
  logic pressed_r;
  logic pressed_nxt;
  logic [LED_N-1:0] led_lit_r;
  logic [LED_N-1:0] led_lit_nxt;
  logic [SEG_N-1:0] seg_lit_r;
  logic [SEG_N-1:0] seg_lit_nxt;
  // ****************************************
  // Write decode
  // ****************************************
  always_comb begin
    dir_we = '0;
    data_we = '0;
    if (wr_i) begin
      case (addr_i)
        OFS_SWITCH_DATA: data_we[0] = 1'b1;
        OFS_SWITCH_DIR: dir_we[0] = 1'b1;
        OFS_LED_DATA: data_we[1] = 1'b1;
        OFS_LED_DIR: dir_we[1] = 1'b1;
        OFS_SEG_DATA: data_we[2] = 1'b1;
        OFS_SEG_DIR: dir_we[2] = 1'b1;
        default: data_we = '0;
      endcase
    end
  end
  assign pin_in[0] = switch_pin_i;
  assign pin_in[1] = led_pin_i;
  assign pin_in[2] = seg_pin_i;
  // ****************************************
  // Ports: switch, LED, segment
  // ****************************************
  genvar p;
  generate
    for (p = 0; p < PORT_CNT; p++) begin : g_port
      bio_port #(
        .W(PORT_W)
      ) u_port (
        .mclk_i(mclk_i),
        .reset_i(reset_i),
        .dir_we_i(dir_we[p]),
        .data_we_i(data_we[p]),
        .wdata_i(wdata_i),
        .pin_i(pin_in[p]),
        .pin_o(pin_out[p]),
        .pin_oe_o(pin_oe[p]),
        .rdata_o(port_rd[p])
      );
    end
  endgenerate
  assign switch_pin_o = pin_out[0];
  assign switch_pin_oe_o = pin_oe[0];
  assign led_pin_o = pin_out[1];
  assign led_pin_oe_o = pin_oe[1];
  assign seg_pin_o = pin_out[2];
  assign seg_pin_oe_o = pin_oe[2];
  // ****************************************
  // Board level views
  // ****************************************
  always_comb begin
    pressed_nxt = ~port_rd[0][SW_PIN]; // R4
    for (int i = 0; i < LED_N; i++) begin
      led_lit_nxt[i] = led_pin_oe_o[i] & ~led_pin_o[i]; // R5
    end
    for (int i = 0; i < SEG_N; i++) begin
      seg_lit_nxt[i] = seg_pin_oe_o[i] & ~seg_pin_o[i]; // R6
    end
  end
  // ****************************************
  // Board level view registers
  // ****************************************
  always_ff @(posedge mclk_i) begin
    if (reset_i) begin
      pressed_r <= 1'b0;
      led_lit_r <= '0;
      seg_lit_r <= '0;
    end else begin
      pressed_r <= pressed_nxt;
      led_lit_r <= led_lit_nxt;
      seg_lit_r <= seg_lit_nxt;
    end
  end
  assign push_switch_a_pressed_o = pressed_r;
  assign led_lit_o = led_lit_r;
  assign seg_lit_o = seg_lit_r;
  // ****************************************
  // Read data
  // ****************************************
  always_comb begin
    rdata_nxt = '0;
    if (rd_i) begin
      case (addr_i)
        OFS_SWITCH_DATA: rdata_nxt = port_rd[0]; // R3 R4
        OFS_SWITCH_DIR: rdata_nxt = pin_oe[0];
        OFS_LED_DATA: rdata_nxt = port_rd[1];
        OFS_LED_DIR: rdata_nxt = pin_oe[1];
        OFS_SEG_DATA: rdata_nxt = port_rd[2];
        OFS_SEG_DIR: rdata_nxt = pin_oe[2];
        default: rdata_nxt = UNMAPPED_RD;
      endcase
    end
  end
  always_ff @(posedge mclk_i) begin
    if (reset_i) begin
      rdata_r <= '0;
    end else begin
      rdata_r <= rdata_nxt;
    end
  end
  assign rdata_o = rdata_r;
endmodule : bio_top

// file: common/bio_pkg.sv
package bio_pkg;
  // ****************************************
  // Geometry
  // ****************************************
  localparam int PORT_W = 8;
  localparam int ADDR_W = 4;
  localparam int LED_N = 4;
  localparam int SEG_N = 8;
  localparam int SW_PIN = 5;
  // ****************************************
  // Register offsets
  // ****************************************
  localparam logic [3:0] OFS_SWITCH_DATA = 4'h0;
  localparam logic [3:0] OFS_SWITCH_DIR = 4'h1;
  localparam logic [3:0] OFS_LED_DATA = 4'h2;
  localparam logic [3:0] OFS_LED_DIR = 4'h3;
  localparam logic [3:0] OFS_SEG_DATA = 4'h4;
  localparam logic [3:0] OFS_SEG_DIR = 4'h5;
  localparam int PORT_CNT = 3;
  // ****************************************
  // Reset values
  // ****************************************
  localparam logic [7:0] DIR_RST = 8'h00;
  localparam logic [7:0] DATA_RST = 8'hFF;
  localparam logic [7:0] UNMAPPED_RD = 8'h00;
endpackage : bio_pkg

// file: src/bio_port.sv
`timescale 1ns/10ps
module bio_port
  import bio_pkg::*;
#(
  parameter int W = PORT_W
) (
  input wire logic mclk_i,
  input wire logic reset_i,
  input wire logic dir_we_i,
  input wire logic data_we_i,
  input wire logic [W-1:0] wdata_i,
  input wire logic [W-1:0] pin_i,
  output logic [W-1:0] pin_o,
  output logic [W-1:0] pin_oe_o,
  output logic [W-1:0] rdata_o
);
  logic [W-1:0] dir_r;
  logic [W-1:0] dir_nxt;
  logic [W-1:0] data_r;
  logic [W-1:0] data_nxt;
  // ****************************************
  // Next values
  // ****************************************
  always_comb begin
    dir_nxt = dir_r;
    data_nxt = data_r;
    if (dir_we_i) begin
      dir_nxt = wdata_i;
    end
    if (data_we_i) begin
      data_nxt = wdata_i;
    end
  end
  always_ff @(posedge mclk_i) begin
    if (reset_i) begin
      dir_r <= W'(DIR_RST); // R7
      data_r <= W'(DATA_RST);
    end else begin
      dir_r <= dir_nxt;
      data_r <= data_nxt;
    end
  end
  // ****************************************
  // Pin drive and readback
  // ****************************************
  genvar g;
  generate
    for (g = 0; g < W; g++) begin : g_bit
      assign pin_oe_o[g] = dir_r[g]; // R1 R2
      assign pin_o[g] = data_r[g]; // R2
      assign rdata_o[g] = dir_r[g] ? data_r[g] : pin_i[g]; // R1 R3
    end
  endgenerate
endmodule : bio_port

// file: tb/bio_chk.sv
`timescale 1ns/10ps
module bio_chk (
  input wire logic mclk_i,
  input wire logic reset_i,
  input wire logic wr_i,
  input wire logic rd_i,
  input wire logic push_switch_a_pressed_o,
  input wire logic [3:0] addr_i,
  input wire logic [3:0] led_lit_o,
  input wire logic [7:0] wdata_i,
  input wire logic [7:0] rdata_o,
  input wire logic [7:0] switch_pin_i,
  input wire logic [7:0] switch_pin_oe_o,
  input wire logic [7:0] led_pin_o,
  input wire logic [7:0] led_pin_oe_o,
  input wire logic [7:0] seg_pin_o,
  input wire logic [7:0] seg_pin_oe_o,
  input wire logic [7:0] seg_lit_o
);
  default clocking @(posedge mclk_i); endclocking
  default disable iff (reset_i);
  sequence s_no_read;
    !rd_i;
  endsequence
  sequence s_seg_data_write;
    wr_i && addr_i == 4'h4;
  endsequence
  a_reset_dir: assert property ($fell(reset_i) |->
    (switch_pin_oe_o | led_pin_oe_o | seg_pin_oe_o) == 8'h00)
    else $error("dir reset");
  a_data_write: assert property (s_seg_data_write |=>
    seg_pin_o == $past(wdata_i)) else $error("data write");
  a_rdata_idle: assert property (s_no_read |=>
    rdata_o == 8'h00) else $error("rdata idle");
  a_dir_write: assert property (wr_i && addr_i == 4'h3 |=>
    led_pin_oe_o == $past(wdata_i)) else $error("dir write");
  a_input_read: assert property (rd_i && addr_i == 4'h0 &&
    switch_pin_oe_o == 8'h00 |=> rdata_o == $past(switch_pin_i))
    else $error("input read");
  a_switch_low: assert property (!switch_pin_oe_o[5] |=>
    push_switch_a_pressed_o == !$past(switch_pin_i[5]))
    else $error("switch");
  a_led_lit: assert property (led_lit_o ==
    ($past(led_pin_oe_o[3:0]) & ~$past(led_pin_o[3:0])))
    else $error("led lit");
  a_seg_lit: assert property (seg_lit_o ==
    ($past(seg_pin_oe_o) & ~$past(seg_pin_o))) else $error("seg lit");
endmodule : bio_chk
bind bio_top bio_chk u_chk (.*);

// file: tb/bio_pins.sv
`timescale 1ns/10ps
module bio_pins (
  input wire logic [7:0] ext_i,
  input wire logic [7:0] pin_i,
  input wire logic [7:0] oe_i,
  output logic [7:0] lvl_o
);
  // Undriven bits show the far side level
  assign lvl_o = (oe_i & pin_i) | (~oe_i & ext_i);
endmodule : bio_pins

// file: tb/bio_top_test.sv
`timescale 1ns/10ps
`define CHK(n, e, g) begin total_checks++; if ((g) !== (e)) begin \
  err_count++; $display("[FAIL] %s exp %h got %h", n, e, g); end end
module bio_top_test;
  logic mclk_i = 0, reset_i = 1, wr = 0, rd = 0, press = 0, prs;
  logic [3:0] addr = 4'h0, lit;
  logic [7:0] wd = 8'h00, rdata, sl, ll, gl, so, soe, lo, loe, go, goe, glit;
  int err_count = 0, total_checks = 0, cyc = 0;
  bio_top DUT (.mclk_i, .reset_i, .addr_i(addr), .wdata_i(wd), .wr_i(wr),
    .rd_i(rd), .rdata_o(rdata), .switch_pin_i(sl), .switch_pin_o(so),
    .switch_pin_oe_o(soe), .led_pin_i(ll), .led_pin_o(lo),
    .led_pin_oe_o(loe), .seg_pin_i(gl), .seg_pin_o(go), .seg_pin_oe_o(goe),
    .push_switch_a_pressed_o(prs), .led_lit_o(lit), .seg_lit_o(glit));
  bio_pins u_sw (.ext_i({2'b11, ~press, 5'h03}), .pin_i(so), .oe_i(soe),
    .lvl_o(sl));
  bio_pins u_led (.ext_i(8'hC3), .pin_i(lo), .oe_i(loe), .lvl_o(ll));
  bio_pins u_seg (.ext_i(8'h3C), .pin_i(go), .oe_i(goe), .lvl_o(gl));
  initial forever #25 mclk_i = ~mclk_i;
  always @(posedge mclk_i) if (++cyc == 500) begin
    err_count++;
    complete_run();
  end
  task automatic wr_reg(input logic [3:0] a, input logic [7:0] d);
    addr <= a;
    wd <= d;
    wr <= 1'b1;
    @(posedge mclk_i);
    wr <= 1'b0;
    #1;
  endtask : wr_reg
  task automatic rd_chk(input string n, input logic [3:0] a,
    input logic [7:0] e);
    addr <= a;
    rd <= 1'b1;
    @(posedge mclk_i);
    rd <= 1'b0;
    #1;
    `CHK(n, e, rdata)
  endtask : rd_chk
  task automatic t_reset();
    rd_chk("sw dir", 4'h1, 8'h00);
    rd_chk("led dir", 4'h3, 8'h00);
    rd_chk("seg dir", 4'h5, 8'h00);
    `CHK("oe", 8'h00, soe | loe | goe)
  endtask : t_reset
  task automatic t_switch();
    rd_chk("sw up", 4'h0, 8'hE3);
    `CHK("released", 1'b0, prs)
    press <= 1'b1;
    rd_chk("sw down", 4'h0, 8'hC3);
    `CHK("pressed", 1'b1, prs)
    wr_reg(4'h0, 8'h0E);
    wr_reg(4'h1, 8'h01);
    `CHK("sw oe", 8'h01, soe)
    `CHK("sw out", 8'h0E, so)
    rd_chk("sw mix", 4'h0, 8'hC2);
  endtask : t_switch
  task automatic t_led();
    wr_reg(4'h3, 8'h0F);
    wr_reg(4'h2, 8'hFA);
    `CHK("led oe", 8'h0F, loe)
    `CHK("led out", 8'hFA, lo)
    @(posedge mclk_i);
    #1;
    `CHK("led lit", 4'h5, lit)
    rd_chk("led rd", 4'h2, 8'hCA);
  endtask : t_led
  task automatic t_seg();
    wr_reg(4'h4, 8'h7E);
    @(posedge mclk_i);
    #1;
    `CHK("seg off", 8'h00, glit)
    wr_reg(4'h5, 8'hFF);
    @(posedge mclk_i);
    #1;
    `CHK("seg lit", 8'h81, glit)
    `CHK("seg out", 8'h7E, go)
    wr_reg(4'hF, 8'hFF);
    rd_chk("unmapped", 4'hF, 8'h00);
    rd_chk("seg rd", 4'h4, 8'h7E);
  endtask : t_seg
  task automatic t_rerun();
    reset_i <= 1'b1;
    repeat (2) @(posedge mclk_i);
    reset_i <= 1'b0;
    @(posedge mclk_i);
    #1;
    `CHK("oe rst", 8'h00, soe | loe | goe)
    `CHK("data rst", 8'hFF, lo & go)
    `CHK("lit rst", 4'h0, lit)
    rd_chk("led dir rst", 4'h3, 8'h00);
  endtask : t_rerun
  task automatic complete_run();
    $display("checks %0d errors %0d", total_checks, err_count);
    if (err_count == 0 && total_checks > 0)
      $display("NO MISMATCHES");
    else
      $display("MISMATCHES SEEN");
    $finish;
  endtask : complete_run
  initial begin
    repeat (4) @(posedge mclk_i);
    reset_i <= 1'b0;
    @(posedge mclk_i);
    t_reset();
    t_switch();
    t_led();
    t_seg();
    t_rerun();
    complete_run();
  end
endmodule : bio_top_test
